/* File: rtcl_byte_mem.sv */
/*
 * Small byte store for the oscillator, pin and alarm internal registers.
 * Read data come out of a register one cycle after rd_en; all bytes are
 * also visible in parallel for the compare and oscillator controls.
 */
`timescale 1ns/10ps
`default_nettype none

module rtcl_byte_mem
   import rtcl_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   input  wire logic                   wr_en,
   input  wire logic [2:0]             wr_idx,
   input  wire logic [7:0]             wr_data,
   input  wire logic                   rd_en,
   input  wire logic [2:0]             rd_idx,
   output logic      [7:0]             rd_data,
   output logic      [MEM_DEPTH*8-1:0] all_q
);

   logic [7:0] mem_q [MEM_DEPTH];
   logic [7:0] mem_d [MEM_DEPTH];
   logic [7:0] rd_q;
   logic [7:0] rd_d;

   genvar gi;
   generate
      for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_byte
         always_comb begin
            mem_d[gi] = mem_q[gi];
            if (wr_en && (wr_idx == 3'(gi))) begin
               mem_d[gi] = wr_data;
            end
         end
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               mem_q[gi] <= MEM_RESET;
            end else begin
               mem_q[gi] <= mem_d[gi];
            end
         end
         assign all_q[gi*8 +: 8] = mem_q[gi];
      end
   endgenerate

   always_comb begin
      rd_d = rd_q;
      if (rd_en) begin
         rd_d = (rd_idx < 3'(MEM_DEPTH)) ? mem_q[rd_idx] : 8'h00;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= 8'h00;
      end else begin
         rd_q <= rd_d;
      end
   end

   assign rd_data = rd_q;

endmodule

`default_nettype wire

/* File: rtcl_core.sv */
/*
 * Locked indirect-access real-time counter: key machine, address and
 * data interface registers, indirect access engine, 32-bit counter with
 * alarm compare and missing-oscillator detection.
 * Assumes the host port is synchronous to ref_clk with one-cycle strobes
 * and that lf_osc_ok reports a running low-frequency oscillator.
 */
`timescale 1ns/10ps
`default_nettype none

module rtcl_core
   import rtcl_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire rtcl_sfr_req_type sfr_req,
   output logic      [7:0]       sfr_rdata,
   input  wire logic             lf_osc_ok,
   output logic                  alarm_event,
   output logic                  missing_osc_event,
   output rtcl_osc_out_type      osc_out
);

   ////////////////////////////////////////////////////////////////////////
   // State

   rtcl_key_state_type key_q, key_d;
   logic [7:0]  adr_q, adr_d;
   logic [7:0]  dat_q, dat_d;
   logic [3:0]  cnt_q, cnt_d;
   logic        opwr_q, opwr_d;
   logic [7:0]  rdata_q, rdata_d;
   logic [7:0]  ctl_q, ctl_d;
   logic [31:0] capt_q, capt_d;
   logic [31:0] tmr_q, tmr_d;
   logic [11:0] div_q, div_d;
   logic        alm_ev_q, miss_ev_q;

   logic        ind_wr;
   logic [3:0]  ind_idx;
   logic        mem_rd;
   logic [3:0]  mem_rd_adr;
   logic [7:0]  mem_rdata;
   logic [MEM_DEPTH*8-1:0] mem_all;
   logic [7:0]  rd_val;
   logic [7:0]  stat_code;
   logic        open_if, busy, done, is_multi;
   logic        acc_adr_dat, key_wr;
   logic        tick, alarm_hit, miss_hit;
   logic [31:0] alarm_val;

   ////////////////////////////////////////////////////////////////////////
   // Interface registers and key machine

   assign open_if     = (key_q == KS_UNLOCKED);
   assign busy        = (cnt_q != 4'h0);
   assign done        = (cnt_q == 4'h1);
   assign key_wr      = sfr_req.wr && (sfr_req.sel == SEL_KEY);
   assign acc_adr_dat = (sfr_req.wr || sfr_req.rd)
                        && (sfr_req.sel == SEL_ADR || sfr_req.sel == SEL_DAT);
   assign ind_idx     = adr_q[3:0];
   assign is_multi    = (ind_idx <= IA_CAPTURE0 + 4'h3)
                        || (ind_idx >= IA_ALARM0 && ind_idx <= IA_LAST);

   always_comb begin
      unique case (key_q)
         KS_LOCKED:   stat_code = STAT_LOCKED;
         KS_FIRST:    stat_code = STAT_FIRST;
         KS_UNLOCKED: stat_code = STAT_OPEN;
         KS_DISABLED: stat_code = STAT_DISABLED;
      endcase
   end

   // Internal read mux; holes in the map read as zero
   always_comb begin
      if (ind_idx <= IA_CAPTURE0 + 4'h3) begin
         rd_val = capt_q[ind_idx[1:0]*8 +: 8];
      end else if (ind_idx == IA_CONTROL) begin
         rd_val = ctl_q;
      end else if (ind_idx <= IA_LAST) begin
         rd_val = mem_rdata;
      end else begin
         rd_val = 8'h00;
      end
   end

   always_comb begin
      key_d      = key_q;
      adr_d      = adr_q;
      dat_d      = dat_q;
      cnt_d      = cnt_q;
      opwr_d     = opwr_q;
      rdata_d    = rdata_q;
      ind_wr     = 1'b0;
      mem_rd     = 1'b0;
      mem_rd_adr = adr_q[3:0];
      // Status read never touches the key machine
      if (sfr_req.rd) begin
         unique case (sfr_req.sel)
            SEL_KEY: rdata_d = stat_code; // RULE_13 RULE_17
            SEL_ADR: rdata_d = open_if ? adr_q : 8'h00;
            SEL_DAT: rdata_d = open_if ? dat_q : 8'h00;
            default: rdata_d = 8'h00;
         endcase
      end
      if (key_wr) begin
         unique case (key_q)
            KS_LOCKED:   key_d = (sfr_req.wdata == KEY_FIRST) ? KS_FIRST : KS_DISABLED; // RULE_10
            KS_FIRST:    key_d = (sfr_req.wdata == KEY_SECOND) ? KS_UNLOCKED : KS_DISABLED; // RULE_09
            KS_UNLOCKED: key_d = KS_LOCKED; // RULE_12
            KS_DISABLED: key_d = KS_DISABLED; // RULE_17
         endcase
      end else if (acc_adr_dat && !open_if && key_q != KS_DISABLED) begin
         key_d = KS_DISABLED; // RULE_10
      end
      // Busy countdown for an indirect access in flight
      if (busy) begin
         cnt_d = cnt_q - 4'h1;
      end
      // Completion of an indirect access
      if (done) begin
         cnt_d         = 4'h0;
         adr_d[ADR_BUSY] = 1'b0;
         if (opwr_q) begin
            ind_wr = 1'b1; // RULE_18
         end else begin
            dat_d = rd_val; // RULE_18
         end
         if (is_multi) begin
            adr_d[1:0] = adr_q[1:0] + 2'h1; // RULE_19
         end
      end
      // New accesses are only taken when idle; writes while busy are dropped
      if (open_if && !busy) begin // RULE_01 RULE_11
         if (sfr_req.wr && sfr_req.sel == SEL_ADR) begin
            adr_d = sfr_req.wdata;
            if (sfr_req.wdata[ADR_BUSY]) begin
               cnt_d      = sfr_req.wdata[ADR_SHORT] ? ACC_SHORT : ACC_LONG; // RULE_18
               opwr_d     = 1'b0;
               mem_rd     = 1'b1;
               mem_rd_adr = sfr_req.wdata[3:0];
            end
         end else if (sfr_req.wr && sfr_req.sel == SEL_DAT) begin
            dat_d           = sfr_req.wdata;
            adr_d[ADR_BUSY] = 1'b1;
            cnt_d           = adr_q[ADR_SHORT] ? ACC_SHORT : ACC_LONG; // RULE_18
            opwr_d          = 1'b1;
         end else if (sfr_req.rd && sfr_req.sel == SEL_DAT && adr_q[ADR_AUTORD]) begin
            adr_d[ADR_BUSY] = 1'b1;
            cnt_d           = adr_q[ADR_SHORT] ? ACC_SHORT : ACC_LONG;
            opwr_d          = 1'b0;
            mem_rd          = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         key_q   <= KS_LOCKED; // RULE_20
         adr_q   <= ADR_RESET;
         dat_q   <= DAT_RESET;
         cnt_q   <= 4'h0;
         opwr_q  <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         key_q   <= key_d;
         adr_q   <= adr_d;
         dat_q   <= dat_d;
         cnt_q   <= cnt_d;
         opwr_q  <= opwr_d;
         rdata_q <= rdata_d;
      end
   end

   rtcl_byte_mem u_mem (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .wr_en   (ind_wr && ind_idx >= MEM_BASE && ind_idx <= IA_LAST),
      .wr_idx  (3'(ind_idx - MEM_BASE)),
      .wr_data (dat_q),
      .rd_en   (mem_rd),
      .rd_idx  (3'(mem_rd_adr - MEM_BASE)),
      .rd_data (mem_rdata),
      .all_q   (mem_all)
   );

   ////////////////////////////////////////////////////////////////////////
   // Counter, alarm and oscillator watch

   assign alarm_val = mem_all[(IA_ALARM0 - MEM_BASE)*8 +: 32]; // RULE_07
   assign tick      = (div_q == LF_DIV_LAST); // RULE_14
   assign alarm_hit = tick && ctl_q[CTL_RUN] && lf_osc_ok && ctl_q[CTL_ALM_EN]
                      && (tmr_q + 32'h0000_0001 == alarm_val);
   // One pulse per loss; rearmed when software clears the flag
   assign miss_hit  = ctl_q[CTL_RUN] && !lf_osc_ok && !ctl_q[CTL_MISS_FLAG];

   always_comb begin
      div_d  = tick ? 12'h000 : div_q + 12'h001;
      ctl_d  = ctl_q;
      capt_d = capt_q;
      tmr_d  = tmr_q;
      if (ind_wr && ind_idx <= IA_CAPTURE0 + 4'h3) begin
         capt_d[ind_idx[1:0]*8 +: 8] = dat_q; // RULE_02
      end
      if (ind_wr && ind_idx == IA_CONTROL) begin
         ctl_d = dat_q; // RULE_03
         // Flags clear on a written 0 and stay on a written 1
         ctl_d[CTL_ALM_FLAG]  = dat_q[CTL_ALM_FLAG] & ctl_q[CTL_ALM_FLAG];
         ctl_d[CTL_MISS_FLAG] = dat_q[CTL_MISS_FLAG] & ctl_q[CTL_MISS_FLAG];
      end
      if (ctl_q[CTL_LOAD]) begin
         tmr_d           = capt_q; // RULE_02
         ctl_d[CTL_LOAD] = 1'b0;
      end else if (tick && ctl_q[CTL_RUN] && lf_osc_ok) begin
         tmr_d = tmr_q + 32'h0000_0001; // RULE_14
      end
      if (ctl_q[CTL_CAPT]) begin
         capt_d          = tmr_q;
         ctl_d[CTL_CAPT] = 1'b0;
      end
      // Hardware set beats a same-cycle clear
      if (alarm_hit) begin
         ctl_d[CTL_ALM_FLAG] = 1'b1; // RULE_16
      end
      if (miss_hit) begin
         ctl_d[CTL_MISS_FLAG] = 1'b1; // RULE_16
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q     <= 12'h000;
         ctl_q     <= CTL_RESET;
         capt_q    <= 32'h0000_0000;
         tmr_q     <= 32'h0000_0000;
         alm_ev_q  <= 1'b0;
         miss_ev_q <= 1'b0;
      end else begin
         div_q     <= div_d;
         ctl_q     <= ctl_d;
         capt_q    <= capt_d;
         tmr_q     <= tmr_d;
         alm_ev_q  <= alarm_hit;
         miss_ev_q <= miss_hit;
      end
   end

   assign sfr_rdata                 = rdata_q;
   assign alarm_event               = alm_ev_q;
   assign missing_osc_event         = miss_ev_q;
   assign osc_out.osc_ctrl          = mem_all[(IA_OSC_CTRL - MEM_BASE)*8 +: 8]; // RULE_04
   assign osc_out.load_cap          = mem_all[(IA_OSC_CFG - MEM_BASE)*8 + CFG_CAP_LSB +: 4]; // RULE_15
   assign osc_out.auto_cap_stepping = mem_all[(IA_OSC_CFG - MEM_BASE)*8 + CFG_AUTO_CAP_STEPPING]; // RULE_05
   assign osc_out.pins_shorted      = mem_all[(IA_PIN_CFG - MEM_BASE)*8 + PIN_SHORT]; // RULE_06

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_busy_short;
      adr_q[ADR_BUSY] [*6] ##1 !adr_q[ADR_BUSY];
   endsequence

   sequence s_busy_long;
      adr_q[ADR_BUSY] [*7] ##1 !adr_q[ADR_BUSY];
   endsequence

   property p_first_key;
      @(posedge ref_clk) disable iff (!rst_n)
      key_wr && key_q == KS_LOCKED |=>
         key_q == ((($past(sfr_req.wdata)) == KEY_FIRST) ? KS_FIRST : KS_DISABLED);
   endproperty
   a_first_key: assert property (p_first_key) else $error("first key misjudged"); // RULE_10

   property p_second_key;
      @(posedge ref_clk) disable iff (!rst_n)
      key_wr && key_q == KS_FIRST && sfr_req.wdata == KEY_SECOND |=> key_q == KS_UNLOCKED;
   endproperty
   a_second_key: assert property (p_second_key) else $error("unlock failed"); // RULE_09

   property p_relock;
      @(posedge ref_clk) disable iff (!rst_n)
      key_wr && open_if |=> key_q == KS_LOCKED && sfr_rdata == $past(sfr_rdata);
   endproperty
   a_relock: assert property (p_relock) else $error("no relock"); // RULE_12

   property p_disabled_stays;
      @(posedge ref_clk) disable iff (!rst_n)
      key_q == KS_DISABLED |=> key_q == KS_DISABLED && (!adr_q[ADR_BUSY] || $past(busy));
   endproperty
   a_disabled_stays: assert property (p_disabled_stays) else $error("disable left"); // RULE_17

   property p_locked_access;
      @(posedge ref_clk) disable iff (!rst_n)
      acc_adr_dat && !open_if |=> key_q == KS_DISABLED && $stable(dat_q);
   endproperty
   a_locked_access: assert property (p_locked_access) else $error("locked access"); // RULE_10

   property p_status_read;
      @(posedge ref_clk) disable iff (!rst_n)
      sfr_req.rd && sfr_req.sel == SEL_KEY && !key_wr |=>
         sfr_rdata == {6'h00, $past(key_q)} && key_q == $past(key_q);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong"); // RULE_13

   property p_write_timing;
      @(posedge ref_clk) disable iff (!rst_n)
      open_if && !busy && sfr_req.wr && sfr_req.sel == SEL_DAT |=>
         if (adr_q[ADR_SHORT]) s_busy_short else s_busy_long;
   endproperty
   a_write_timing: assert property (p_write_timing) else $error("write length wrong"); // RULE_18

   property p_autoinc;
      @(posedge ref_clk) disable iff (!rst_n)
      done && is_multi && !(open_if && sfr_req.wr && sfr_req.sel == SEL_ADR) |=>
         adr_q[1:0] == $past(adr_q[1:0]) + 2'h1 && adr_q[3:2] == $past(adr_q[3:2]);
   endproperty
   a_autoinc: assert property (p_autoinc) else $error("no auto-increment"); // RULE_19

   property p_alarm;
      @(posedge ref_clk) disable iff (!rst_n)
      alarm_hit |=> alarm_event && ctl_q[CTL_ALM_FLAG] && tmr_q == alarm_val;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm missed"); // RULE_16

endmodule

`default_nettype wire

/* File: rtcl_pkg.sv */
/*
 * Shared constants and types for the locked indirect-access real-time
 * counter: interface selects, key codes, internal map, field positions,
 * reset values and timing.
 * Assumes a single 100 MHz system clock and an active-low async reset.
 */
// Notes on behaviour
// [RULE_01] Only key, address and data registers are host visible; internals are indirect.
// [RULE_02] Internal 0x00-0x03 are capture bytes for loading and reading the counter.
// [RULE_03] Internal 0x04 is the counter control register.
// [RULE_04] Internal 0x05 is the low-frequency oscillator control register.
// [RULE_05] Internal 0x06 holds load capacitance select and automatic stepping enable.
// [RULE_06] Internal 0x07 can short both crystal pins; reserved bits kept as written.
// [RULE_07] Internal 0x08-0x0B are alarm bytes holding the 32-bit compare value.
// [RULE_08] Software writes first then second key code before any address or data access.
// [RULE_09] No time limit between the two key writes; only order matters.
// [RULE_10] Bad order, wrong code or access while locked disables interface until reset.
// [RULE_11] Once unlocked, any number of indirect accesses are allowed.
// [RULE_12] Any key register write while unlocked locks the interface again.
// [RULE_13] Key register read returns status and never disturbs the key sequence.
// [RULE_14] Counter is 32 bits with alarm compare, ticking at about 32 kHz.
// [RULE_15] Load capacitance select offers 16 levels.
// [RULE_16] Alarm and missing-oscillator events are produced for reset or wake-up use.
// [RULE_17] Key status reads 0 locked, 1 first code, 2 unlocked, 3 disabled.
// [RULE_18] Data write starts indirect write; setting busy starts indirect read into data.
// [RULE_19] Address auto-increments after each capture or alarm access, always.
// [RULE_20] Reset returns the key machine to locked, clearing disable and partial key.

package rtcl_pkg;

   localparam int          CLK_HZ       = 100_000_000;
   localparam int          LF_HZ        = 32_768;
   localparam logic [11:0] LF_DIV_LAST  = 12'((CLK_HZ / LF_HZ) - 1);

   localparam logic [1:0]  SEL_KEY      = 2'h0;
   localparam logic [1:0]  SEL_ADR      = 2'h1;
   localparam logic [1:0]  SEL_DAT      = 2'h2;

   localparam logic [7:0]  KEY_FIRST    = 8'hA5;
   localparam logic [7:0]  KEY_SECOND   = 8'hF1;

   localparam logic [7:0]  STAT_LOCKED  = 8'h00;
   localparam logic [7:0]  STAT_FIRST   = 8'h01;
   localparam logic [7:0]  STAT_OPEN    = 8'h02;
   localparam logic [7:0]  STAT_DISABLED = 8'h03;

   localparam logic [3:0]  IA_CAPTURE0  = 4'h0;
   localparam logic [3:0]  IA_CONTROL   = 4'h4;
   localparam logic [3:0]  IA_OSC_CTRL  = 4'h5;
   localparam logic [3:0]  IA_OSC_CFG   = 4'h6;
   localparam logic [3:0]  IA_PIN_CFG   = 4'h7;
   localparam logic [3:0]  IA_ALARM0    = 4'h8;
   localparam logic [3:0]  IA_LAST      = 4'hB;

   localparam int          ADR_BUSY     = 7;
   localparam int          ADR_AUTORD   = 6;
   localparam int          ADR_SHORT    = 4;
   localparam logic [7:0]  ADR_RESET    = 8'h10;
   localparam logic [7:0]  DAT_RESET    = 8'h00;

   localparam logic [3:0]  ACC_LONG     = 4'h7;
   localparam logic [3:0]  ACC_SHORT    = 4'h6;

   localparam int          CTL_RUN      = 0;
   localparam int          CTL_ALM_EN   = 1;
   localparam int          CTL_LOAD     = 2;
   localparam int          CTL_CAPT     = 3;
   localparam int          CTL_ALM_FLAG = 4;
   localparam int          CTL_MISS_FLAG = 5;
   localparam logic [7:0]  CTL_RESET    = 8'h00;

   localparam int          MEM_DEPTH    = 7;
   localparam logic [3:0]  MEM_BASE     = IA_OSC_CTRL;
   localparam logic [7:0]  MEM_RESET    = 8'h00;
   localparam int          CFG_CAP_LSB  = 0;
   localparam int          CFG_AUTO_CAP_STEPPING = 7;
   localparam int          PIN_SHORT    = 7;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [1:0] sel;
      logic [7:0] wdata;
   } rtcl_sfr_req_type;

   typedef struct packed {
      logic [7:0] osc_ctrl;
      logic [3:0] load_cap;
      logic       auto_cap_stepping;
      logic       pins_shorted;
   } rtcl_osc_out_type;

   typedef enum logic [1:0] {
      KS_LOCKED,
      KS_FIRST,
      KS_UNLOCKED,
      KS_DISABLED
   } rtcl_key_state_type;

endpackage

/* File: tb.sv */
/*
 * Self-checking bench for the locked indirect-access real-time counter:
 * key machine, indirect reads and writes, auto-increment, oscillator
 * outputs, alarm and missing-oscillator events.
 * Assumes rtcl_pkg and rtcl_core are compiled first; no external model.
 */
`timescale 1ns/10ps
`default_nettype none

module tb
   import rtcl_pkg::*;
;
   logic             ref_clk;
   logic             rst_n;
   logic             lf_osc_ok;
   rtcl_sfr_req_type sfr_req;
   logic [7:0]       sfr_rdata;
   logic             alarm_event;
   logic             missing_osc_event;
   rtcl_osc_out_type osc_out;
   logic [7:0]       exp_q[$];
   logic             rd_seen = 1'b0;
   logic [7:0]       bytes_v[4];
   int               n_mismatch = 0;
   int               checked = 0;
   int               cycles = 0;
   int               n_alarm = 0;
   int               n_miss = 0;

   rtcl_core DUT (
      .ref_clk           (ref_clk),
      .rst_n             (rst_n),
      .sfr_req           (sfr_req),
      .sfr_rdata         (sfr_rdata),
      .lf_osc_ok         (lf_osc_ok),
      .alarm_event       (alarm_event),
      .missing_osc_event (missing_osc_event),
      .osc_out           (osc_out)
   );

   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      if (n_mismatch == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_out(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Cycle limit well above the alarm and missing-oscillator waits
   always @(posedge ref_clk) begin
      rd_seen <= sfr_req.rd;
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   // Read data settle one edge after the strobe; look half a cycle later
   always @(negedge ref_clk) begin
      if (rd_seen === 1'b1) begin
         cmp_byte("sfr_rdata", exp_q.pop_front(), sfr_rdata);
      end
      if (alarm_event === 1'b1) begin
         n_alarm++;
      end
      if (missing_osc_event === 1'b1) begin
         n_miss++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // One strobe cycle, then a quiet cycle so no signal is driven twice per step
   task automatic host(input logic w, input logic r, input logic [1:0] s, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_req <= '{wr: w, rd: r, sel: s, wdata: d};
      @(posedge ref_clk);
      sfr_req <= '0;
   endtask

   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      host(1'b1, 1'b0, s, d);
   endtask

   task automatic rd(input logic [1:0] s, input logic [7:0] e);
      exp_q.push_back(e);
      host(1'b0, 1'b1, s, 8'h00);
   endtask

   task automatic iwr(input logic [3:0] a, input logic [7:0] d);
      wr(SEL_ADR, {4'h1, a});
      wr(SEL_DAT, d);
      idle(8);
   endtask

   task automatic ird(input logic [3:0] a, input logic [7:0] e);
      wr(SEL_ADR, {4'h9, a});
      idle(8);
      rd(SEL_DAT, e);
   endtask

   task automatic do_reset();
      rst_n   <= 1'b0;
      idle(4);
      rst_n   <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int         i;
      int         b;
      logic [3:0] base;
      logic [7:0] v;
      sfr_req   = '0;
      lf_osc_ok = 1'b1;
      rst_n     = 1'b0;
      void'($urandom(22989));
      idle(4);
      rst_n <= 1'b1;
      rd(SEL_KEY, STAT_LOCKED);
      // Each way of breaking the key sequence, then recovery by reset
      for (b = 0; b < 3; b++) begin
         if (b == 0) begin
            wr(SEL_KEY, KEY_SECOND);
         end else if (b == 1) begin
            wr(SEL_KEY, KEY_FIRST);
            wr(SEL_KEY, 8'h5A);
         end else begin
            rd(SEL_ADR, 8'h00);
         end
         rd(SEL_KEY, STAT_DISABLED);
         wr(SEL_KEY, KEY_FIRST);
         wr(SEL_KEY, KEY_SECOND);
         rd(SEL_KEY, STAT_DISABLED);
         rd(SEL_DAT, 8'h00);
         do_reset();
         rd(SEL_KEY, STAT_LOCKED);
      end
      wr(SEL_KEY, KEY_FIRST);
      rd(SEL_KEY, STAT_FIRST);
      idle(1 + $urandom_range(200));
      rd(SEL_KEY, STAT_FIRST);
      wr(SEL_KEY, KEY_SECOND);
      rd(SEL_KEY, STAT_OPEN);
      rd(SEL_ADR, ADR_RESET);
      rd(2'h3, 8'h00);
      // Capture then alarm group: four writes, wrap check, autoread back
      for (b = 0; b < 2; b++) begin
         base = (b == 0) ? IA_CAPTURE0 : IA_ALARM0;
         for (i = 0; i < 4; i++) bytes_v[i] = 8'($urandom);
         wr(SEL_ADR, {4'h1, base});
         for (i = 0; i < 4; i++) begin
            wr(SEL_DAT, bytes_v[i]);
            idle(8);
         end
         rd(SEL_ADR, {4'h1, base});
         wr(SEL_ADR, {4'hD, base});
         idle(8);
         for (i = 0; i < 4; i++) begin
            rd(SEL_DAT, bytes_v[i]);
            idle(8);
         end
         wr(SEL_ADR, 8'h10);
      end
      // Busy shows while an indirect write is in flight
      v = 8'($urandom);
      wr(SEL_ADR, {4'h1, IA_OSC_CTRL});
      wr(SEL_DAT, v);
      rd(SEL_ADR, {4'h9, IA_OSC_CTRL});
      idle(8);
      ird(IA_OSC_CTRL, v);
      cmp_out("osc_ctrl", v, osc_out.osc_ctrl);
      for (i = 0; i < 16; i++) begin
         v = {1'($urandom), 3'b000, 4'(i)};
         iwr(IA_OSC_CFG, v);
         ird(IA_OSC_CFG, v);
         cmp_out("load_cap", {4'h0, v[3:0]}, {4'h0, osc_out.load_cap});
         cmp_out("auto_cap_stepping", {7'h0, v[7]}, {7'h0, osc_out.auto_cap_stepping});
      end
      rd(SEL_ADR, {4'h1, IA_OSC_CFG});
      for (i = 0; i < 2; i++) begin
         v = {1'(i), 7'($urandom)};
         iwr(IA_PIN_CFG, v);
         ird(IA_PIN_CFG, v);
         cmp_out("pins_shorted", {7'h0, v[7]}, {7'h0, osc_out.pins_shorted});
      end
      // Alarm at count 3, then a stopped oscillator
      wr(SEL_ADR, {4'h1, IA_ALARM0});
      for (i = 0; i < 4; i++) begin
         wr(SEL_DAT, (i == 0) ? 8'h03 : 8'h00);
         idle(8);
      end
      iwr(IA_CONTROL, 8'h02);
      ird(IA_CONTROL, 8'h02);
      rd(SEL_ADR, {4'h1, IA_CONTROL});
      iwr(IA_CONTROL, 8'h03);
      for (i = 0; i < 15000 && n_alarm == 0; i++) idle(1);
      cmp_out("alarm_event count", 8'd1, 8'(n_alarm));
      lf_osc_ok <= 1'b0;
      for (i = 0; i < 4000 && n_miss == 0; i++) idle(1);
      idle(3100);
      cmp_out("missing_osc_event count", 8'd1, 8'(n_miss));
      ird(IA_CONTROL, 8'h33);
      lf_osc_ok <= 1'b1;
      iwr(IA_CONTROL, 8'h00);
      ird(IA_CONTROL, 8'h00);
      // Load counter from capture, spoil capture, then copy counter back
      for (i = 0; i < 4; i++) bytes_v[i] = 8'($urandom);
      wr(SEL_ADR, {4'h1, IA_CAPTURE0});
      for (i = 0; i < 4; i++) begin
         wr(SEL_DAT, bytes_v[i]);
         idle(8);
      end
      iwr(IA_CONTROL, 8'h04);
      iwr(IA_CAPTURE0, ~bytes_v[0]);
      iwr(IA_CONTROL, 8'h08);
      ird(IA_CONTROL, 8'h00);
      wr(SEL_ADR, {4'hD, IA_CAPTURE0});
      idle(8);
      for (i = 0; i < 4; i++) begin
         rd(SEL_DAT, bytes_v[i]);
         idle(8);
      end
      // Relock by any key write, then unlock again
      wr(SEL_KEY, 8'($urandom));
      rd(SEL_KEY, STAT_LOCKED);
      wr(SEL_KEY, KEY_FIRST);
      wr(SEL_KEY, KEY_SECOND);
      rd(SEL_KEY, STAT_OPEN);
      idle(4);
      wrap_up();
   end

endmodule

`default_nettype wire
